// ---- pwmc_top.sv ----
`timescale 1ns/1ps
`include "pwmc_params.svh"
module pwmc_top #(
  parameter int unsigned CLK_LONG_CYC = `PWMC_CLK_LONG_CYC,
  parameter int unsigned CLK_SHORT_CYC = `PWMC_CLK_SHORT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_chip_select_n,
  input wire logic [15:0] i_frame_word,
  input wire logic i_ext_clk,
  input wire logic [pwmc_pkg::PWMC_NPIN-1:0] i_direct_control_pin,
  output logic [pwmc_pkg::PWMC_NCH-1:0] o_output_channels,
  output logic o_clock_fail
);
  import pwmc_pkg::*;

  localparam int NCH = PWMC_NCH;

  // Two-flop synchronisers; the third flop on the clock and chip select only feeds edge detection.
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [15:0] word_s1_q, word_s2_q;
  logic [PWMC_NPIN-1:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      word_s1_q <= 16'h0000;
      word_s2_q <= 16'h0000;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      cs_s1_q <= i_chip_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ext_s1_q <= i_ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      word_s1_q <= i_frame_word;
      word_s2_q <= word_s1_q;
      pin_s1_q <= i_direct_control_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // The frame word is stable well before chip select rises, so it is settled when the edge is seen.
  logic cs_rise, ext_rise;
  pwmc_frame_t frame;
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign frame = pwmc_frame_t'(word_s2_q);

  logic wr_chan, wr_out, wr_glb, wr_inen, wr_presc, wr_ramp, wr_sync;
  assign wr_chan = cs_rise && frame.addr >= `PWMC_ADDR_CHAN_FIRST
    && frame.addr < 4'(`PWMC_ADDR_CHAN_FIRST + NCH);
  assign wr_out = cs_rise && frame.addr == `PWMC_ADDR_OUTCTL;
  assign wr_glb = cs_rise && frame.addr == `PWMC_ADDR_GLOBAL;
  assign wr_inen = cs_rise && frame.addr == `PWMC_ADDR_INEN;
  assign wr_presc = cs_rise && frame.addr == `PWMC_ADDR_PRESC;
  assign wr_ramp = cs_rise && frame.addr == `PWMC_ADDR_RAMP;
  assign wr_sync = cs_rise && frame.addr == `PWMC_ADDR_INIT2 && word_s2_q[`PWMC_SYNC_BIT];

  // External clock monitor: a period outside the window marks the clock failed.
  pwmc_clk_state_t clk_st_q;
  logic [11:0] mon_cnt_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      clk_st_q <= PWMC_CLK_FAIL;
      mon_cnt_q <= 12'h000;
    end else if (ext_rise) begin
      mon_cnt_q <= 12'h000;
      if (mon_cnt_q + 12'h001 < 12'(CLK_SHORT_CYC)) begin
        clk_st_q <= PWMC_CLK_FAIL;
      end else if (mon_cnt_q < 12'(CLK_LONG_CYC)) begin
        clk_st_q <= PWMC_CLK_OK;
      end
    end else if (mon_cnt_q >= 12'(CLK_LONG_CYC)) begin
      clk_st_q <= PWMC_CLK_FAIL;
    end else begin
      mon_cnt_q <= mon_cnt_q + 12'h001;
    end
  end

  // Common step counter; two spare bits serve the slower prescaler settings.
  logic [9:0] cnt_q;
  logic step_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_q <= 10'h000;
      step_q <= 1'b0;
    end else if (wr_sync) begin
      cnt_q <= 10'h000;
      step_q <= 1'b1;
    end else begin
      cnt_q <= ext_rise ? cnt_q + 10'h001 : cnt_q;
      step_q <= ext_rise;
    end
  end

  // Shared registers: duty source select, shared duty and pin-select bits.
  logic [NCH-1:0] gsel_q;
  logic [7:0] gduty_q;
  logic [2*PWMC_NPIN-1:0] inen_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gsel_q <= '0;
      gduty_q <= `PWMC_DUTY_RST;
      inen_q <= '0;
    end else begin
      if (wr_glb && !word_s2_q[`PWMC_SUBSEL_BIT]) begin
        gsel_q <= word_s2_q[NCH-1:0];
      end
      if (wr_glb && word_s2_q[`PWMC_SUBSEL_BIT]) begin
        gduty_q <= frame.channel_duty_value;
      end
      if (wr_inen) begin
        inen_q <= word_s2_q[2*PWMC_NPIN-1:0];
      end
    end
  end

  logic clk_bad;
  assign clk_bad = (clk_st_q == PWMC_CLK_FAIL);

  pwmc_chan_t ch_q [NCH];
  logic [NCH-1:0] tgt_on, act_on_q, pstart;
  logic [7:0] tgt_duty [NCH];
  logic [7:0] act_duty_q [NCH];
  logic [7:0] pos [NCH];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic [1:0] shift;
      logic [1:0] step_code;
      logic [8:0] step_amt, ramp_sum;
      logic [7:0] base, ramp_duty;
      logic use_glb, pin_sel_hi, pin_sel_lo, pin;

      // Channel word, mirrored on bit, prescaler and ramp share one register per channel.
      assign step_code = (gi < PWMC_NRAMP) ? word_s2_q[2*gi+:2] : 2'h0;
      assign step_amt = (step_code == 2'h0) ? 9'h000 : (9'h002 << step_code);
      assign ramp_sum = word_s2_q[`PWMC_RAMP_DIR_BIT] ? {1'b0, ch_q[gi].duty} + step_amt
        : {1'b0, ch_q[gi].duty} - step_amt;
      assign ramp_duty = ramp_sum[8] ? (word_s2_q[`PWMC_RAMP_DIR_BIT] ? `PWMC_DUTY_FULL
        : `PWMC_DUTY_ZERO) : ramp_sum[7:0];

      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          ch_q[gi] <= '{on: 1'b0, phase: 2'h0, presc: `PWMC_PRESC_RST, duty: `PWMC_DUTY_RST};
        end else begin
          if (wr_chan && frame.addr == 4'(`PWMC_ADDR_CHAN_FIRST + gi)) begin
            ch_q[gi].on <= frame.on;
            ch_q[gi].phase <= {frame.phase_code_msb, frame.phase_code_lsb};
            ch_q[gi].duty <= frame.channel_duty_value;
          end else if (wr_out) begin
            ch_q[gi].on <= word_s2_q[gi];
          end else if (wr_ramp && gi < PWMC_NRAMP) begin
            ch_q[gi].duty <= ramp_duty;
          end
          if (wr_presc && word_s2_q[`PWMC_SUBSEL_BIT] == (gi >= NCH / 2)) begin
            ch_q[gi].presc <= word_s2_q[2*(gi%(NCH/2))+:2];
          end
        end
      end

      // Duty source and gating per the pin-select bits; channels without a pin behave as 00.
      if (gi < PWMC_NPIN) begin : g_pin
        assign pin_sel_hi = inen_q[2*gi+1];
        assign pin_sel_lo = inen_q[2*gi];
        assign pin = pin_s2_q[gi];
      end else begin : g_nopin
        assign pin_sel_hi = 1'b0;
        assign pin_sel_lo = 1'b0;
        assign pin = 1'b0;
      end
      assign use_glb = (pin_sel_hi && pin_sel_lo) ? gsel_q[gi] ^ pin : gsel_q[gi];
      assign tgt_on[gi] = ch_q[gi].on && ((pin_sel_hi == pin_sel_lo) || pin);
      assign tgt_duty[gi] = use_glb ? gduty_q : ch_q[gi].duty;

      // Prescaler picks which counter bits form the step; phase subtracts quarter periods.
      assign shift = ch_q[gi].presc[1] ? 2'h0 : (ch_q[gi].presc[0] ? 2'h1 : 2'h2);
      assign base = cnt_q[shift+:8];
      assign pos[gi] = base - {ch_q[gi].phase, 6'h00};
      assign pstart[gi] = step_q && pos[gi] == 8'h00 && (cnt_q & ((10'h001 << shift) - 10'h001)) == 10'h000;

      // Off and full duty take effect at once; partial duty waits for the period start.
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          act_on_q[gi] <= 1'b0;
          act_duty_q[gi] <= `PWMC_DUTY_RST;
        end else if (!tgt_on[gi] || tgt_duty[gi] == `PWMC_DUTY_FULL) begin
          act_on_q[gi] <= tgt_on[gi];
          act_duty_q[gi] <= tgt_duty[gi];
        end else if (pstart[gi]) begin
          act_on_q[gi] <= tgt_on[gi];
          act_duty_q[gi] <= tgt_duty[gi];
        end
      end

      // A failed clock bypasses the counter compare, so outputs fall back to plain on/off.
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          o_output_channels[gi] <= 1'b0;
        end else if (clk_bad) begin
          o_output_channels[gi] <= tgt_on[gi];
        end else begin
          o_output_channels[gi] <= act_on_q[gi] && pos[gi] <= act_duty_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_clock_fail <= 1'b1;
    end else begin
      o_clock_fail <= clk_bad;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_sync_frame;
    wr_sync;
  endsequence

  // On a failed clock the output follows the target level, so a fresh turn-on may show one edge later.
  sequence s_off_follows;
    !act_on_q[1] ##1 (!o_output_channels[1] || $past(tgt_on[1]));
  endsequence

  sequence s_ramp_up_at_top;
    wr_ramp && word_s2_q[`PWMC_RAMP_DIR_BIT] && ch_q[0].duty == `PWMC_DUTY_FULL;
  endsequence

  property p_fail_full;
    (clk_bad && tgt_on[0]) |=> o_output_channels[0];
  endproperty
  a_fail_full: assert property (p_fail_full) else $error("enabled output not full on failed clock");

  property p_off_now;
    !tgt_on[1] |=> s_off_follows;
  endproperty
  a_off_now: assert property (p_off_now) else $error("turn-off not applied at once");

  property p_defer;
    (tgt_on[0] && act_on_q[0] && tgt_duty[0] != `PWMC_DUTY_FULL && !pstart[0]) |=> $stable(act_duty_q[0]);
  endproperty
  a_defer: assert property (p_defer) else $error("partial duty applied before period start");

  property p_sync;
    s_sync_frame |=> cnt_q == 10'h000 && step_q;
  endproperty
  a_sync: assert property (p_sync) else $error("sync frame did not clear counter");

  property p_saturate;
    s_ramp_up_at_top |=> ch_q[0].duty == `PWMC_DUTY_FULL;
  endproperty
  a_saturate: assert property (p_saturate) else $error("ramp wrapped past top");

  property p_sixth_kept;
    wr_ramp |=> $stable(ch_q[NCH-1].duty) && $stable(gduty_q);
  endproperty
  a_sixth_kept: assert property (p_sixth_kept) else $error("ramp touched sixth channel or shared duty");

  property p_mirror;
    (wr_out && word_s2_q[2]) |=> ch_q[2].on;
  endproperty
  a_mirror: assert property (p_mirror) else $error("output control write missed on bit");

  property p_shared;
    gsel_q[NCH-1] |-> tgt_duty[NCH-1] == gduty_q;
  endproperty
  a_shared: assert property (p_shared) else $error("shared duty not used");

  property p_fast_clk;
    (ext_rise && mon_cnt_q + 12'h001 < 12'(CLK_SHORT_CYC)) |=> ##1 o_clock_fail;
  endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("fast clock not flagged");

  property p_ramp_step;
    (wr_ramp && word_s2_q[`PWMC_RAMP_DIR_BIT] && word_s2_q[1:0] == 2'h1 && ch_q[0].duty < 8'hF0)
      |=> ch_q[0].duty == $past(ch_q[0].duty) + 8'h04;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step of four wrong");

  property p_floor;
    (wr_ramp && !word_s2_q[`PWMC_RAMP_DIR_BIT] && word_s2_q[5:4] == 2'h2 && ch_q[2].duty < 8'h08)
      |=> ch_q[2].duty == `PWMC_DUTY_ZERO;
  endproperty
  a_floor: assert property (p_floor) else $error("ramp wrapped below zero");

  property p_pin_gate;
    (inen_q[1:0] == 2'h1 && !pin_s2_q[0]) |-> !tgt_on[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("low pin did not gate channel");

  property p_pin_swap;
    (inen_q[1:0] == 2'h3 && pin_s2_q[0] && !gsel_q[0]) |-> tgt_duty[0] == gduty_q;
  endproperty
  a_pin_swap: assert property (p_pin_swap) else $error("high pin did not swap duty source");

  property p_own_duty;
    (inen_q[5:4] == 2'h0 && !gsel_q[2]) |-> tgt_duty[2] == ch_q[2].duty;
  endproperty
  a_own_duty: assert property (p_own_duty) else $error("individual duty not used");

  property p_presc_now;
    (wr_presc && !word_s2_q[`PWMC_SUBSEL_BIT]) |=> ch_q[0].presc == $past(word_s2_q[1:0]);
  endproperty
  a_presc_now: assert property (p_presc_now) else $error("prescaler write not applied at once");

  property p_slow_clk;
    (!ext_rise && mon_cnt_q >= 12'(CLK_LONG_CYC)) |=> ##1 o_clock_fail;
  endproperty
  a_slow_clk: assert property (p_slow_clk) else $error("stopped clock not flagged");
endmodule

// ---- pwmc_params.svh ----
`ifndef PWMC_PARAMS_SVH
`define PWMC_PARAMS_SVH

// Frame address codes.
`define PWMC_ADDR_INIT2 4'h1
`define PWMC_ADDR_CHAN_FIRST 4'h2
`define PWMC_ADDR_OUTCTL 4'h8
`define PWMC_ADDR_GLOBAL 4'h9
`define PWMC_ADDR_INEN 4'hB
`define PWMC_ADDR_PRESC 4'hC
`define PWMC_ADDR_RAMP 4'hE

// Field positions inside a 16-bit frame.
`define PWMC_SYNC_BIT 1
`define PWMC_SUBSEL_BIT 8
`define PWMC_RAMP_DIR_BIT 10

// Reset values, duty limits and the phase offset shift.
`define PWMC_DUTY_FULL 8'hFF
`define PWMC_DUTY_ZERO 8'h00
`define PWMC_DUTY_RST 8'h00
`define PWMC_PRESC_RST 2'h0
`define PWMC_PHASE_LSB 6

// External clock window, in Hz, and the reference clock rate.
`define PWMC_REF_HZ 10000000
`define PWMC_CLK_MIN_HZ 25600
`define PWMC_CLK_MAX_HZ 102400
`define PWMC_CLK_LONG_CYC (`PWMC_REF_HZ / `PWMC_CLK_MIN_HZ)
`define PWMC_CLK_SHORT_CYC ((`PWMC_REF_HZ + `PWMC_CLK_MAX_HZ - 1) / `PWMC_CLK_MAX_HZ)

`endif

// ---- pwmc_pkg.sv ----
package pwmc_pkg;
  localparam int unsigned PWMC_NCH = 6;
  localparam int unsigned PWMC_NPIN = 4;
  localparam int unsigned PWMC_NRAMP = 5;

  typedef struct packed {
    logic [3:0] addr;
    logic frame_toggle_bit;
    logic phase_code_msb;
    logic phase_code_lsb;
    logic on;
    logic [7:0] channel_duty_value;
  } pwmc_frame_t;

  typedef struct packed {
    logic on;
    logic [1:0] phase;
    logic [1:0] presc;
    logic [7:0] duty;
  } pwmc_chan_t;

  typedef enum logic [0:0] {
    PWMC_CLK_FAIL = 1'b0,
    PWMC_CLK_OK = 1'b1
  } pwmc_clk_state_t;
endpackage

// ---- pwmc_host_model.sv ----
`timescale 1ns/1ps
module pwmc_host_model (
  input wire logic i_ref_clk,
  output logic o_chip_select_n,
  output logic [15:0] o_frame_word
);
  initial begin
    o_chip_select_n = 1'b1;
    o_frame_word = 16'h0000;
  end
  // After the hold time the word shows its inverse, so a late sample of it cannot pass by luck.
  task automatic write_frame(input logic [15:0] w);
    @(posedge i_ref_clk);
    o_chip_select_n <= 1'b0;
    o_frame_word <= w;
    repeat (2) @(posedge i_ref_clk);
    o_chip_select_n <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    o_frame_word <= ~w;
  endtask
endmodule

// ---- pwmc_top_tb.sv ----
`timescale 1ns/1ps
module pwmc_top_tb;
  import pwmc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b1;
  realtime ext_half = 400.0;
  logic [PWMC_NPIN-1:0] pins = 4'h0;
  logic cs_n;
  logic [15:0] word;
  logic [PWMC_NCH-1:0] outs;
  logic clk_fail;
  int mismatches = 0;
  int checks = 0;
  int cnt[PWMC_NCH];

  pwmc_host_model pwmc_host_model_inst (.i_ref_clk(i_ref_clk), .o_chip_select_n(cs_n), .o_frame_word(word));
  pwmc_top #(.CLK_LONG_CYC(40), .CLK_SHORT_CYC(4)) pwmc_top_inst (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_chip_select_n(cs_n),
    .i_frame_word(word),
    .i_ext_clk(ext_clk),
    .i_direct_control_pin(pins),
    .o_output_channels(outs),
    .o_clock_fail(clk_fail)
  );

  initial begin
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // The odd start offset keeps link edges clear of reference edges.
  initial begin
    #37;
    forever begin
      #(ext_half);
      if (ext_run) begin
        ext_clk = ~ext_clk;
      end
    end
  end

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_near(input int got, input int exp, input int tol);
    checks++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bits(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Returns once the frame's immediate effects have reached the outputs.
  task automatic send(input logic [15:0] w);
    pwmc_host_model_inst.write_frame(w);
    repeat (3) @(negedge i_ref_clk);
  endtask

  function automatic logic [15:0] chw(input int ch, input logic [1:0] ph, input logic on, input logic [7:0] d);
    return {4'(ch + 1), 1'b0, ph, on, d};
  endfunction

  task automatic measure(input int n);
    foreach (cnt[c]) cnt[c] = 0;
    repeat (n) begin
      @(negedge i_ref_clk);
      foreach (cnt[c]) cnt[c] += (outs[c] === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic expect_cnt(input int e[PWMC_NCH], input int tol);
    foreach (e[c]) check_near(cnt[c], e[c], tol);
  endtask

  initial begin
    #4000000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check_bits({clk_fail, outs}, 7'h40);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (60) @(negedge i_ref_clk);
    check_bits({clk_fail, outs}, 7'h00);
    send(16'hC006);
    send(16'hC12A);
    send(chw(1, 2'h0, 1'b1, 8'h0F));
    send(chw(2, 2'h0, 1'b1, 8'h0F));
    send(chw(3, 2'h0, 1'b1, 8'h0F));
    send(chw(4, 2'h1, 1'b1, 8'h0F));
    send(16'h1002);
    measure(448);
    expect_cnt('{128, 256, 448, 0, 0, 0}, 8);
    measure(1152);
    expect_cnt('{0, 0, 64, 128, 0, 0}, 8);
    send(16'h8000);
    check_bits({clk_fail, outs}, 7'h00);
    send(chw(1, 2'h0, 1'b1, 8'hFE));
    check_bits({clk_fail, outs}, 7'h00);
    send(chw(1, 2'h0, 1'b1, 8'hFF));
    check_bits({clk_fail, outs}, 7'h01);
    send(16'h8000);
    send(16'hC02A);
    send(16'h913F);
    send(16'h9002);
    send(chw(1, 2'h0, 1'b1, 8'h7F));
    send(chw(2, 2'h0, 1'b1, 8'h10));
    send(chw(3, 2'h0, 1'b1, 8'h07));
    send(chw(4, 2'h1, 1'b1, 8'hF8));
    send(chw(6, 2'h0, 1'b1, 8'h7F));
    send(16'hE4CF);
    send(16'hE020);
    repeat (2100) @(negedge i_ref_clk);
    measure(2048);
    expect_cnt('{1152, 512, 8, 2048, 0, 1024}, 0);
    send(16'hB001);
    repeat (16) @(negedge i_ref_clk);
    measure(2048);
    check_near(cnt[0], 0, 0);
    @(posedge i_ref_clk);
    pins <= 4'h1;
    repeat (2100) @(negedge i_ref_clk);
    measure(2048);
    check_near(cnt[0], 1152, 0);
    send(16'hB003);
    repeat (2100) @(negedge i_ref_clk);
    measure(2048);
    check_near(cnt[0], 512, 0);
    ext_run = 1'b0;
    repeat (80) @(negedge i_ref_clk);
    check_bits({clk_fail, outs}, 7'h6F);
    ext_run = 1'b1;
    repeat (100) @(negedge i_ref_clk);
    check_bits({6'h00, clk_fail}, 7'h00);
    send(16'hB000);
    send(chw(3, 2'h0, 1'b0, 8'hFF));
    send(chw(1, 2'h0, 1'b0, 8'hEC));
    send(16'h8004);
    check_bits({clk_fail, outs}, 7'h04);
    send(16'hE401);
    send(16'h8005);
    repeat (2100) @(negedge i_ref_clk);
    measure(2048);
    check_near(cnt[0], 1928, 0);
    check_near(cnt[2], 2048, 0);
    send(16'hE403);
    send(16'hE403);
    measure(2048);
    check_near(cnt[0], 2048, 0);
    ext_half = 100.0;
    repeat (40) @(negedge i_ref_clk);
    check_bits({6'h00, clk_fail}, 7'h01);
    give_verdict();
  end
endmodule
